// file: src/frequency_trim_register_bank.sv
// Frequency trim register bank: offset word, output enable and pull range
// ****************************************
// Behaviour
// R1 - Low offset word at 0x00, resets zero
// R2 - High ten offset bits at 0x01[9:0]
// R3 - Offset word is signed two's complement
// R4 - Offset zero after reset until written
// R5 - Only high word write changes applied offset
// R6 - Master writes low word before high
// R7 - Bit 0x01[10] software output enable, default off
// R8 - Hardware enable mode ignores software enable writes
// R9 - Bits 0x01[15:11] read zero, ignore writes
// R10 - 0x02[3:0] pull range code, rest read-only
// R11 - All controls writable by the serial master; 0x01[10] writes are ignored in hardware enable mode
// R12 - Sixteen codes map 6.25 to 3200 ppm
// R13 - Master limits offset updates to 38 kHz
// R14 - Master rewrites enable with high word
// R15 - Full offset applied at once on high write
// ****************************************
`timescale 1ns/100ps
`default_nettype none

module frequency_trim_register_bank (
    input  wire logic                clk_in,
    input  wire logic                rst_b_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    input  wire trim_pkg::addr_t     reg_addr_in,
    input  wire trim_pkg::data_t     reg_wdata_in,
    output trim_pkg::data_t          reg_rdata_out,
    input  wire logic                oe_hw_mode_in,
    input  wire logic                oe_pin_in,
    output trim_pkg::offset_t        freq_offset_out,
    output logic                     freq_update_out,
    output logic                     output_drive_en_out,
    output trim_pkg::range_code_t    pull_range_code_out,
    output trim_pkg::range_ppm_t     pull_range_ppm_out
);
    import trim_pkg::*;

    data_t       low_r;
    high_t       high_r;
    logic        sw_oe_r;
    range_code_t range_r;
    offset_t     freq_offset_r;
    logic        freq_update_r;
    data_t       rdata_r;
    logic        hw_mode_r;
    logic        strap_done_r;
    logic        pin_s1_r;
    logic        pin_s2_r;
    logic        pin_s3_r;
    logic        pin_state_r;
    logic        drive_en_r;
    logic        high_seen_r;
    logic        wr_low;
    logic        wr_high;
    logic        wr_range;
    data_t       rdata_nxt;

    trim_if rng ();

    assign wr_low   = reg_wr_in && (reg_addr_in == `TRIM_ADDR_LOW);
    assign wr_high  = reg_wr_in && (reg_addr_in == `TRIM_ADDR_HIGH);
    assign wr_range = reg_wr_in && (reg_addr_in == `TRIM_ADDR_RANGE);

    // ****************************************
    // Offset word staging and apply
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            low_r <= `TRIM_LOW_RST; // R1
        end else if (wr_low) begin
            low_r <= reg_wdata_in; // R1 R11
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            high_r <= `TRIM_HIGH_RST;
        end else if (wr_high) begin
            high_r <= reg_wdata_in[`TRIM_HIGH_MSB:0]; // R2 R9
        end
    end

    // Low word may be staged without touching the oscillator; high write commits
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            freq_offset_r <= {`TRIM_HIGH_RST, `TRIM_LOW_RST}; // R4
            freq_update_r <= 1'b0;
        end else begin
            freq_update_r <= wr_high;
            if (wr_high) begin
                freq_offset_r <= {reg_wdata_in[`TRIM_HIGH_MSB:0], low_r}; // R3 R5 R15 R6
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            high_seen_r <= 1'b0;
        end else if (wr_high) begin
            high_seen_r <= 1'b1;
        end
    end

    // ****************************************
    // Output enable control
    // ****************************************
    // Strap caught once after reset release, never under the async reset
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hw_mode_r    <= 1'b0;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            hw_mode_r    <= oe_hw_mode_in;
            strap_done_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sw_oe_r <= `TRIM_OE_RST; // R7
        // Strap not latched yet on the first edge; read it live so hardware mode still blocks
        end else if (wr_high && !(strap_done_r ? hw_mode_r : oe_hw_mode_in)) begin
            sw_oe_r <= reg_wdata_in[`TRIM_OE_BIT]; // R7 R8 R14
        end
    end

    // Pin crosses in; a level counts once the later stages agree
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_s1_r    <= 1'b0;
            pin_s2_r    <= 1'b0;
            pin_s3_r    <= 1'b0;
            pin_state_r <= 1'b0;
        end else begin
            pin_s1_r <= oe_pin_in;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pin_s2_r == pin_s3_r) begin
                pin_state_r <= pin_s3_r;
            end
        end
    end

    // Driver stays off until the strap is known
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            drive_en_r <= 1'b0;
        end else if (!strap_done_r) begin
            drive_en_r <= 1'b0;
        end else begin
            drive_en_r <= hw_mode_r ? pin_state_r : sw_oe_r; // R8
        end
    end

    // ****************************************
    // Pull range
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            range_r <= `TRIM_RANGE_RST;
        end else if (wr_range) begin
            range_r <= reg_wdata_in[`TRIM_RANGE_MSB:0]; // R10 R11
        end
    end

    assign rng.code = range_r;

    pull_range_decode u_decode (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .rng      (rng.dec)
    ); // R12

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        rdata_nxt = '0;
        case (reg_addr_in)
            `TRIM_ADDR_LOW:   rdata_nxt = low_r;
            `TRIM_ADDR_HIGH:  rdata_nxt = {5'h00, sw_oe_r, high_r}; // R9
            `TRIM_ADDR_RANGE: rdata_nxt = {12'h000, range_r}; // R10
            default:          rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_r <= '0;
        end else if (reg_rd_in) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_out       = rdata_r;
    assign freq_offset_out     = freq_offset_r;
    assign freq_update_out     = freq_update_r;
    assign output_drive_en_out = drive_en_r;
    assign pull_range_code_out = range_r;
    assign pull_range_ppm_out  = rng.range_ppm;

    // ****************************************
    // Checks
    // ****************************************
    property p_low_no_apply;
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_low |=> freq_offset_r == $past(freq_offset_r);
    endproperty
    a_low_no_apply: assert property (p_low_no_apply) else $error("Low write moved offset"); // R5

    property p_high_apply;
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_high |=> freq_offset_r == {$past(reg_wdata_in[9:0]), low_r};
    endproperty
    a_high_apply: assert property (p_high_apply) else $error("High write did not apply offset"); // R15

    property p_update_pulse;
        @(posedge clk_in) disable iff (!rst_b_in)
        freq_update_r == $past(wr_high);
    endproperty
    a_update_pulse: assert property (p_update_pulse) else $error("Update pulse wrong"); // R5

    property p_zero_until_high;
        @(posedge clk_in) disable iff (!rst_b_in)
        !high_seen_r |-> freq_offset_r == 26'h0000000;
    endproperty
    a_zero_until_high: assert property (p_zero_until_high) else $error("Offset not zero before first apply"); // R4

    property p_sw_oe;
        @(posedge clk_in) disable iff (!rst_b_in)
        (wr_high && !hw_mode_r && strap_done_r) |=> sw_oe_r == $past(reg_wdata_in[10]) ##1 drive_en_r == $past(sw_oe_r);
    endproperty
    a_sw_oe: assert property (p_sw_oe) else $error("Software enable not followed"); // R7

    property p_hw_oe;
        @(posedge clk_in) disable iff (!rst_b_in)
        (hw_mode_r && strap_done_r) |=> drive_en_r == $past(pin_state_r);
    endproperty
    a_hw_oe: assert property (p_hw_oe) else $error("Hardware enable mode not followed"); // R8

    property p_high_unused;
        @(posedge clk_in) disable iff (!rst_b_in)
        (reg_rd_in && reg_addr_in == 8'h01) |=> rdata_r[15:11] == 5'h00 && rdata_r[10] == $past(sw_oe_r)
            && rdata_r[9:0] == $past(high_r);
    endproperty
    a_high_unused: assert property (p_high_unused) else $error("High word read wrong"); // R9

    property p_range_rw;
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_range |=> range_r == $past(reg_wdata_in[3:0]);
    endproperty
    a_range_rw: assert property (p_range_rw) else $error("Pull range write lost"); // R10

    property p_range_ro;
        @(posedge clk_in) disable iff (!rst_b_in)
        (reg_rd_in && reg_addr_in == 8'h02) |=> rdata_r[15:4] == 12'h000;
    endproperty
    a_range_ro: assert property (p_range_ro) else $error("Pull range upper bits not zero"); // R10

endmodule

`default_nettype wire

// file: src/pull_range_decode.sv
// Pull range code to half-range span in hundredths of a ppm
`timescale 1ns/100ps
`default_nettype none

module pull_range_decode (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    trim_if.dec       rng
);
    import trim_pkg::*;

    range_ppm_t range_nxt;

    always_comb begin
        case (rng.code)
            4'h0: range_nxt = 19'h00271;
            4'h1: range_nxt = 19'h003E8;
            4'h2: range_nxt = 19'h004E2;
            4'h3: range_nxt = 19'h009C4;
            4'h4: range_nxt = 19'h01388;
            4'h5: range_nxt = 19'h01F40;
            4'h6: range_nxt = 19'h02710;
            4'h7: range_nxt = 19'h030D4;
            4'h8: range_nxt = 19'h03A98;
            4'h9: range_nxt = 19'h04E20;
            4'hA: range_nxt = 19'h09C40;
            4'hB: range_nxt = 19'h0EA60;
            4'hC: range_nxt = 19'h13880;
            4'hD: range_nxt = 19'h1D4C0;
            4'hE: range_nxt = 19'h27100;
            4'hF: range_nxt = 19'h4E200;
            default: range_nxt = 19'h00271;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rng.range_ppm <= 19'h00271;
        end else begin
            rng.range_ppm <= range_nxt;
        end
    end

endmodule

`default_nettype wire

// file: src/trim_consts.svh
// Offsets, field positions, reset values and widths of the frequency trim bank
`ifndef TRIM_CONSTS_SVH
`define TRIM_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define TRIM_ADDR_W          8
`define TRIM_ADDR_LOW        8'h00
`define TRIM_ADDR_HIGH       8'h01
`define TRIM_ADDR_RANGE      8'h02

// ****************************************
// Field layout
// ****************************************
`define TRIM_DATA_W          16
`define TRIM_OFFSET_W        26
`define TRIM_HIGH_W          10
`define TRIM_HIGH_MSB        9
`define TRIM_OE_BIT          10
`define TRIM_RANGE_W         4
`define TRIM_RANGE_MSB       3
`define TRIM_RANGE_PPM_W     19

// ****************************************
// Reset values
// ****************************************
`define TRIM_LOW_RST         16'h0000
`define TRIM_HIGH_RST        10'h000
`define TRIM_OE_RST          1'b0
`define TRIM_RANGE_RST       4'h0

`endif

// file: src/trim_if.sv
// Carrier between the register bank and the pull range decoder
`timescale 1ns/100ps
`default_nettype none

interface trim_if;
    import trim_pkg::*;
    range_code_t code;
    range_ppm_t  range_ppm;
    modport bank (output code, input range_ppm);
    modport dec  (input code, output range_ppm);
endinterface

`default_nettype wire

// file: src/trim_pkg.sv
// Types shared by the frequency trim register bank
`default_nettype none
`include "trim_consts.svh"

package trim_pkg;
    typedef logic [`TRIM_ADDR_W-1:0]      addr_t;
    typedef logic [`TRIM_DATA_W-1:0]      data_t;
    typedef logic [`TRIM_OFFSET_W-1:0]    offset_t;
    typedef logic [`TRIM_HIGH_W-1:0]      high_t;
    typedef logic [`TRIM_RANGE_W-1:0]     range_code_t;
    typedef logic [`TRIM_RANGE_PPM_W-1:0] range_ppm_t;
endpackage

`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the frequency trim register bank
`timescale 1ns/100ps
`default_nettype none
`include "trim_consts.svh"

module testbench;
    import trim_pkg::*;

    logic       clk_in;
    logic       rst_b_in;
    logic       oe_hw_mode_in;
    logic       oe_pin_in;
    logic       reg_wr;
    logic       reg_rd;
    addr_t      reg_addr;
    data_t      reg_wdata;
    data_t      reg_rdata;
    offset_t    freq_offset_out;
    logic       freq_update_out;
    logic       output_drive_en_out;
    range_code_t pull_range_code_out;
    range_ppm_t pull_range_ppm_out;
    int         n_fail;
    int         num_checks;
    int         n_upd;
    data_t      rv;

    frequency_trim_register_bank uut (
        .clk_in                       (clk_in),
        .rst_b_in                     (rst_b_in),
        .reg_wr_in                    (reg_wr),
        .reg_rd_in                    (reg_rd),
        .reg_addr_in                  (reg_addr),
        .reg_wdata_in                 (reg_wdata),
        .reg_rdata_out                (reg_rdata),
        .oe_hw_mode_in                (oe_hw_mode_in),
        .oe_pin_in                    (oe_pin_in),
        .freq_offset_out              (freq_offset_out),
        .freq_update_out              (freq_update_out),
        .output_drive_en_out          (output_drive_en_out),
        .pull_range_code_out          (pull_range_code_out),
        .pull_range_ppm_out           (pull_range_ppm_out)
    );

    trim_master m (
        .clk_in    (clk_in),
        .wr_out    (reg_wr),
        .rd_out    (reg_rd),
        .addr_out  (reg_addr),
        .wdata_out (reg_wdata),
        .rdata_in  (reg_rdata)
    );

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (freq_update_out === 1'b1) begin
            n_upd++;
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input string what, input logic [25:0] exp, input logic [25:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset(input logic hw);
        @(posedge clk_in);
        #1;
        rst_b_in      = 1'b0;
        oe_hw_mode_in = hw;
        repeat (12) @(posedge clk_in);
        #1;
        rst_b_in = 1'b1;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_values();
        chk("offset at reset", 26'h0000000, freq_offset_out);
        chk("drive at reset", 26'h0, output_drive_en_out);
        chk("ppm at reset", 26'h0000271, pull_range_ppm_out);
        m.get(`TRIM_ADDR_LOW, rv);
        chk("low at reset", 26'h0, rv);
        m.get(`TRIM_ADDR_HIGH, rv);
        chk("high at reset", 26'h0, rv);
    endtask

    task automatic t_commit();
        int base;
        base = n_upd;
        m.put(`TRIM_ADDR_LOW, 16'hA5C3);
        settle();
        chk("offset after low", 26'h0000000, freq_offset_out);
        chk("pulses after low", 26'h0, 26'(n_upd - base));
        m.put(`TRIM_ADDR_HIGH, 16'hFE80);
        chk("offset committed", 26'h280A5C3, freq_offset_out);
        chk("pulses after high", 26'h1, 26'(n_upd - base));
        chk("sign bit", 26'h1, freq_offset_out[25]);
        chk("sw drive on", 26'h1, output_drive_en_out);
        m.get(`TRIM_ADDR_HIGH, rv);
        chk("high readback", 26'h0680, rv);
        m.get(`TRIM_ADDR_LOW, rv);
        chk("low readback", 26'hA5C3, rv);
        m.put(`TRIM_ADDR_LOW, 16'h0000);
        m.put(`TRIM_ADDR_HIGH, 16'h0380);
        chk("negative offset", 26'h3800000, freq_offset_out);
        chk("sw drive off", 26'h0, output_drive_en_out);
    endtask

    task automatic t_range();
        m.put(`TRIM_ADDR_RANGE, 16'hFFF9);
        settle();
        chk("range code", 26'h9, pull_range_code_out);
        chk("range ppm 9", 26'h0004E20, pull_range_ppm_out);
        m.get(`TRIM_ADDR_RANGE, rv);
        chk("range readback", 26'h0009, rv);
        m.put(`TRIM_ADDR_RANGE, 16'h000F);
        settle();
        chk("range ppm 15", 26'h004E200, pull_range_ppm_out);
        m.put(8'h03, 16'hFFFF);
        m.get(8'h03, rv);
        chk("unmapped read", 26'h0, rv);
        m.get(`TRIM_ADDR_RANGE, rv);
        chk("range kept", 26'h000F, rv);
    endtask

    task automatic t_hw_oe();
        do_reset(1'b1);
        @(posedge clk_in);
        #1;
        oe_pin_in = 1'b1;
        repeat (8) @(posedge clk_in);
        #1;
        chk("hw drive on", 26'h1, output_drive_en_out);
        m.put(`TRIM_ADDR_HIGH, 16'h0000);
        chk("hw drive kept", 26'h1, output_drive_en_out);
        oe_pin_in = 1'b0;
        repeat (8) @(posedge clk_in);
        #1;
        m.put(`TRIM_ADDR_HIGH, 16'h0400);
        chk("hw drive off", 26'h0, output_drive_en_out);
        m.get(`TRIM_ADDR_HIGH, rv);
        chk("sw enable kept in hw mode", 26'h0, rv);
    endtask

    initial begin
        n_fail        = 0;
        num_checks    = 0;
        n_upd         = 0;
        rst_b_in      = 1'b0;
        oe_hw_mode_in = 1'b0;
        oe_pin_in     = 1'b0;
        do_reset(1'b0);
        t_reset_values();
        t_commit();
        t_range();
        t_hw_oe();
        wrap_up();
    end

    // Whole run is near 4500 cycles; give it ample room
    initial begin
        #(25 * 40000);
        n_fail++;
        wrap_up();
    end
endmodule

`default_nettype wire

// file: testbench/trim_master.sv
// Serial engine stand-in driving register strobes toward the trim bank
`timescale 1ns/100ps
`default_nettype none
`include "trim_consts.svh"

module trim_master (
    input  wire logic            clk_in,
    output logic                 wr_out,
    output logic                 rd_out,
    output trim_pkg::addr_t      addr_out,
    output trim_pkg::data_t      wdata_out,
    input  wire trim_pkg::data_t rdata_in
);
    import trim_pkg::*;

    initial begin
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        addr_out  = 8'hFF;
        wdata_out = 16'h5A5A;
    end

    // ****************************************
    // Register cycles
    // ****************************************
    task automatic put(input addr_t a, input data_t d);
        @(posedge clk_in);
        #1;
        wr_out    = 1'b1;
        addr_out  = a;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        wr_out    = 1'b0;
        // Released lines show the inverse, never a stale value
        addr_out  = ~a;
        wdata_out = ~d;
        if (a === `TRIM_ADDR_HIGH) begin
            repeat (1100) @(posedge clk_in);
        end
    endtask

    task automatic get(input addr_t a, output data_t v);
        @(posedge clk_in);
        #1;
        rd_out   = 1'b1;
        addr_out = a;
        @(posedge clk_in);
        #1;
        rd_out   = 1'b0;
        addr_out = ~a;
        v        = rdata_in;
    endtask
endmodule

`default_nettype wire
